//--- hdl/tic_ctrl.sv
`include "tic_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tic_ctrl (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // processor byte bus
  input wire tic_pkg::tic_bus_t bus_in,
  output logic [7:0] rdata_out,
  // board sources
  input wire tic_pkg::tic_sources_t sources_in,
  input wire logic socket_a_in,
  input wire logic socket_b_in,
  // processor interrupt lines
  output logic normal_irq_out,
  output logic fast_irq_out
);

  // ----------------------------------------
  // bus fields
  // ----------------------------------------
  // read strobe only steers the zero read path
  logic bus_wr;
  logic bus_rd;
  logic [2:0] bus_addr;
  logic [7:0] bus_wdata;
  assign bus_wr = bus_in.wr;
  assign bus_rd = bus_in.rd;
  assign bus_addr = bus_in.addr;
  assign bus_wdata = bus_in.wdata;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic wr_fast_mask;
  logic wr_norm_mask;
  logic wr_fast_cnt;
  logic wr_norm_cnt;

  logic [1:0] wr_mask_sel;
  logic [1:0] wr_count_sel;
  logic clr_bit;

  always_comb begin
    wr_fast_mask = 1'b0;
    wr_norm_mask = 1'b0;
    wr_fast_cnt = 1'b0;
    wr_norm_cnt = 1'b0;
    if (bus_wr) begin
      case (bus_addr)
        `TIC_FAST_ENABLE_ADDR: begin
          wr_fast_mask = 1'b1;
        end
        `TIC_NORMAL_ENABLE_ADDR: begin
          wr_norm_mask = 1'b1;
        end
        `TIC_FAST_COUNT_ADDR: begin
          wr_fast_cnt = 1'b1;
        end
        `TIC_NORMAL_COUNT_ADDR: begin
          wr_norm_cnt = 1'b1;
        end
        default: begin
          wr_fast_mask = 1'b0;
        end
      endcase
    end
  end

  // channel 0 is fast, channel 1 is normal
  assign wr_mask_sel = {wr_norm_mask, wr_fast_mask};
  assign wr_count_sel = {wr_norm_cnt, wr_fast_cnt};

  assign clr_bit = bus_wdata[`TIC_COUNTER_BIT];

  // ----------------------------------------
  // board sources
  // ----------------------------------------
  logic src_timer_ch2;
  logic src_timer_ch1;
  logic src_network;
  logic src_serial_two;
  logic src_serial_one;
  logic src_parallel_one;

  logic socket_any;
  logic [6:0] board_src;
  assign src_timer_ch2 = sources_in.timer_ch2;
  assign src_timer_ch1 = sources_in.timer_ch1;
  assign src_network = sources_in.network;
  assign src_serial_two = sources_in.serial_two;
  assign src_serial_one = sources_in.serial_one;
  assign src_parallel_one = sources_in.parallel_one;
  assign socket_any = socket_a_in | socket_b_in;
  assign board_src = {socket_any, src_timer_ch2, src_timer_ch1, src_network,
    src_serial_two, src_serial_one, src_parallel_one};

  // ----------------------------------------
  // per-channel mask, cycle counter and request
  // ----------------------------------------
  wire logic [1:0][7:0] hit_all;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic [7:0] mask;
    logic [7:0] count;
    logic req;

    logic [7:0] next_mask;
    logic [7:0] next_count;
    logic next_req;

    logic at_zero;
    logic at_idle;
    logic set_req;
    logic clr_req;
    logic [7:0] vec;

    // ----------------------------------------
    // expiry and clear
    // ----------------------------------------
    assign at_zero = (count == `TIC_COUNT_ZERO);
    assign at_idle = (count == `TIC_COUNT_IDLE);
    // a reload in the expiry cycle suppresses that expiry
    assign set_req = at_zero && !wr_count_sel[c];
    assign clr_req = wr_mask_sel[c] && clr_bit;

    // ----------------------------------------
    // mask
    // ----------------------------------------
    always_comb begin
      next_mask = mask;
      if (wr_mask_sel[c]) begin
        next_mask = bus_wdata;
      end
    end

    // undefined for software after reset; zero keeps lines quiet
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        mask <= `TIC_MASK_RESET;
      end else begin
        mask <= next_mask;
      end
    end

    // ----------------------------------------
    // cycle counter
    // ----------------------------------------
    // idle 0xff never decrements; zero steps once to 0xff
    always_comb begin
      next_count = count;
      if (wr_count_sel[c]) begin
        next_count = bus_wdata;
      end else if (!at_idle) begin
        next_count = count - 8'h01;
      end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        count <= `TIC_COUNT_RESET;
      end else begin
        count <= next_count;
      end
    end

    // ----------------------------------------
    // latched request
    // ----------------------------------------
    // set wins over a same-cycle clear so no expiry is lost
    always_comb begin
      next_req = req;
      if (set_req) begin
        next_req = 1'b1;
      end else if (clr_req) begin
        next_req = 1'b0;
      end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        req <= 1'b0;
      end else begin
        req <= next_req;
      end
    end

    // ----------------------------------------
    // gating
    // ----------------------------------------
    // counter request rides on bit 7 beside the board sources
    assign vec = {req, board_src};
    for (genvar b = 0; b < 8; b++) begin : g_bit
      assign hit_all[c][b] = vec[b] & mask[b];
    end
  end

  // ----------------------------------------
  // interrupt outputs
  // ----------------------------------------
  logic next_fast_irq;
  logic next_normal_irq;
  assign next_fast_irq = |hit_all[0];
  assign next_normal_irq = |hit_all[1];

  // ----------------------------------------
  // fast line
  // ----------------------------------------
  // registered so the core never sees a decode glitch
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fast_irq_out <= 1'b0;
    end else begin
      fast_irq_out <= next_fast_irq;
    end
  end

  // ----------------------------------------
  // normal line
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      normal_irq_out <= 1'b0;
    end else begin
      normal_irq_out <= next_normal_irq;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] next_rdata;

  // every slot is write-only or reserved, so each read sees zero
  always_comb begin
    next_rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        3'h0: begin
          next_rdata = 8'h00;
        end
        3'h1: begin
          next_rdata = 8'h00;
        end
        `TIC_FAST_ENABLE_ADDR: begin
          next_rdata = 8'h00;
        end
        `TIC_NORMAL_ENABLE_ADDR: begin
          next_rdata = 8'h00;
        end
        3'h4: begin
          next_rdata = 8'h00;
        end
        3'h5: begin
          next_rdata = 8'h00;
        end
        `TIC_FAST_COUNT_ADDR: begin
          next_rdata = 8'h00;
        end
        `TIC_NORMAL_COUNT_ADDR: begin
          next_rdata = 8'h00;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end

endmodule : tic_ctrl
`default_nettype wire

//--- pkg/tic_map.svh
`ifndef TIC_MAP_SVH
`define TIC_MAP_SVH
// register offsets, indexed by the address field the bus presents
`define TIC_FAST_ENABLE_ADDR 3'h2
`define TIC_NORMAL_ENABLE_ADDR 3'h3
`define TIC_FAST_COUNT_ADDR 3'h6
`define TIC_NORMAL_COUNT_ADDR 3'h7
// field positions
`define TIC_COUNTER_BIT 7
`define TIC_SOCKET_BIT 6
// counter values
`define TIC_COUNT_IDLE 8'hff
`define TIC_COUNT_ZERO 8'h00
// chosen reset values for masks and counters
`define TIC_MASK_RESET 8'h00
`define TIC_COUNT_RESET 8'hff
`endif

//--- pkg/tic_pkg.sv
package tic_pkg;
  // board sources feeding mask bits 5..0
  typedef struct packed {
    logic timer_ch2;
    logic timer_ch1;
    logic network;
    logic serial_two;
    logic serial_one;
    logic parallel_one;
  } tic_sources_t;
  // byte-wide processor write/read strobe group
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tic_bus_t;
endpackage : tic_pkg

//--- sim/tic_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tic_cpu_model (
  input wire logic core_clk_in,
  output var tic_pkg::tic_bus_t bus_out
);
  initial bus_out = '0;
  // idle data inverted so a stale byte never passes as fresh
  task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    bus_out = '{!rd, rd, a, d};
    @(negedge core_clk_in);
    bus_out = '{1'b0, 1'b0, a, ~d};
  endtask : access
endmodule : tic_cpu_model
`default_nettype wire

//--- sim/tic_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tic_ctrl_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire tic_pkg::tic_bus_t bus_in,
  input wire logic [7:0] rdata_out,
  input wire tic_pkg::tic_sources_t sources_in,
  input wire logic socket_a_in,
  input wire logic socket_b_in,
  input wire logic normal_irq_out,
  input wire logic fast_irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // shadow masks; unknown until software writes them
  logic [7:0] fm, nm;
  wire logic [6:0] src = {socket_a_in | socket_b_in, sources_in};
  wire logic fw = bus_in.wr && bus_in.addr == 3'h2;
  wire logic nw = bus_in.wr && bus_in.addr == 3'h3;
  always_ff @(posedge core_clk_in) if (fw) fm <= bus_in.wdata;
  always_ff @(posedge core_clk_in) if (nw) nm <= bus_in.wdata;
  sequence f_arm; bus_in.wr && bus_in.addr == 3'h6 && bus_in.wdata == 8'h00 && fm[7] ##1 !fw [*3]; endsequence
  sequence n_arm; bus_in.wr && bus_in.addr == 3'h7 && bus_in.wdata == 8'h00 && nm[7] ##1 !nw [*3]; endsequence
  rdata_zero_a: assert property (rdata_out == 8'h00) else $error("rdata");
  fast_src_a: assert property (|(fm[6:0] & src) |=> fast_irq_out) else $error("fsrc");
  norm_src_a: assert property (|(nm[6:0] & src) |=> normal_irq_out) else $error("nsrc");
  fast_block_a: assert property (fw && bus_in.wdata == 8'h00 |=> ##1 !fast_irq_out) else $error("fblk");
  norm_block_a: assert property (nw && bus_in.wdata == 8'h00 |=> ##1 !normal_irq_out) else $error("nblk");
  fast_count_a: assert property (f_arm |-> fast_irq_out) else $error("fcnt");
  norm_count_a: assert property (n_arm |-> normal_irq_out) else $error("ncnt");
  reset_quiet_a: assert property ($fell(rst_in) |-> !fast_irq_out && !normal_irq_out) else $error("rst");
endmodule : tic_ctrl_monitor
bind tic_ctrl tic_ctrl_monitor mon (.*);
`default_nettype wire

//--- sim/tic_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tic_ctrl_tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] src = 8'h00, fmv, nmv, want, rdata;
  tic_pkg::tic_bus_t bus;
  logic nirq, firq;
  int bad_count = 0, comparisons = 0, n;
  logic [31:0] rows [9] = '{32'h01010002, 32'h02000201, 32'h04040403, 32'h08770801, 32'h10100002,
    32'h20002001, 32'h40404003, 32'h80400002, 32'h3f404000};
  always #50 core_clk_in = ~core_clk_in;
  tic_cpu_model cpu (.core_clk_in(core_clk_in), .bus_out(bus));
  tic_ctrl uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
    .sources_in(src[5:0]), .socket_a_in(src[6]), .socket_b_in(src[7]), .normal_irq_out(nirq),
    .fast_irq_out(firq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("compared %0d mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(negedge core_clk_in);
    rst_in = 1'b0;
    check(rdata | {6'h00, firq, nirq}, 8'h00);
    for (int r = 0; r < 4; r++) cpu.access(1'b0, {r[1], 1'b1, r[0]}, 8'h00);
    foreach (rows[i]) begin
      {src, fmv, nmv, want} = rows[i];
      cpu.access(1'b0, 3'h2, fmv);
      cpu.access(1'b0, 3'h3, nmv);
      @(negedge core_clk_in);
      check({6'h00, firq, nirq}, want);
    end
    cpu.access(1'b1, 3'h3, 8'h00);
    check(rdata, 8'h00);
    $display("mask rows done");
    // both counters at load 0; fast also at 0xfe, normal at 0x05
    for (int k = 0; k < 4; k++) begin
      fmv = k[1] ? (k[0] ? 8'h05 : 8'hfe) : 8'h00;
      cpu.access(1'b0, {2'h1, k[0]}, 8'h80);
      cpu.access(1'b0, {2'h3, k[0]}, fmv);
      for (n = 0; n < 300 && !(k[0] ? nirq : firq); n++) @(negedge core_clk_in);
      if (n == 300) begin
        bad_count++;
        test_done();
      end
      check(8'(n - 2), fmv);
      repeat (8) @(negedge core_clk_in);
      cpu.access(1'b0, {2'h1, k[0]}, 8'h80);
      check({7'h00, k[0] ? nirq : firq}, 8'h01);
      @(negedge core_clk_in);
      check({7'h00, k[0] ? nirq : firq}, 8'h00);
      repeat (300) @(negedge core_clk_in);
      check({7'h00, k[0] ? nirq : firq}, 8'h00);
      cpu.access(1'b0, {2'h3, k[0]}, 8'hff);
      repeat (300) @(negedge core_clk_in);
      check({7'h00, k[0] ? nirq : firq}, 8'h00);
    end
    $display("counter cases done");
    test_done();
  end
endmodule : tic_ctrl_tb
`default_nettype wire
